// ==== pkg/iolcp_regs.svh ====
// constants of the i/o line configuration and pwm block
`ifndef IOLCP_REGS_SVH
`define IOLCP_REGS_SVH

// setting identifiers carried on the write port
`define IOLCP_ID_LINE3      5'h00
`define IOLCP_ID_LINE4      5'h01
`define IOLCP_ID_LINE5      5'h02
`define IOLCP_ID_SLEEP      5'h03
`define IOLCP_ID_SECOND_PULSE_OUTPUT_SEL   5'h04
`define IOLCP_ID_PWM2_SEL   5'h05
`define IOLCP_ID_TH_MISO    5'h06
`define IOLCP_ID_SMT_MISO   5'h07
`define IOLCP_ID_SMT_MOSI   5'h08
`define IOLCP_ID_SMT_SSEL   5'h09
`define IOLCP_ID_SMT_SCLK   5'h0A
`define IOLCP_ID_SMT_ATTN   5'h0B
`define IOLCP_ID_DUTY1      5'h0C
`define IOLCP_ID_DUTY2      5'h0D
`define IOLCP_ID_PULL_EN    5'h0E
`define IOLCP_ID_PULL_DIR   5'h0F
`define IOLCP_ID_FWD_EN     5'h10
`define IOLCP_ID_BIND       5'h11
`define IOLCP_ID_TIMEOUT    5'h12

// selector encodings
`define IOLCP_SEL_DISABLED  3'h0
`define IOLCP_SEL_SPI       3'h1
`define IOLCP_SEL_ANALOG    3'h2
`define IOLCP_SEL_DIN       3'h3
`define IOLCP_SEL_OUT_LOW   3'h4
`define IOLCP_SEL_OUT_HIGH  3'h5
`define IOLCP_PWM_RSSI      3'h1
`define IOLCP_PWM_PLAIN     3'h2

// reset values
`define IOLCP_RST_LINE3     3'h0
`define IOLCP_RST_LINE4     3'h0
`define IOLCP_RST_LINE5     3'h1
`define IOLCP_RST_SLEEP     3'h0
`define IOLCP_RST_SECOND_PULSE_OUTPUT      3'h1
`define IOLCP_RST_PWM2      3'h0
`define IOLCP_RST_TH_MISO   3'h0
`define IOLCP_RST_SMT       3'h1
`define IOLCP_RST_DUTY      10'h000
`define IOLCP_RST_PULL_EN   8'hFF
`define IOLCP_RST_PULL_DIR  8'hFF
`define IOLCP_RST_FWD       1'h1
`define IOLCP_RST_BIND      16'h0000
`define IOLCP_RST_TIMEOUT   8'hFF
`define IOLCP_BIND_ANY      16'hFFFF

// pull mask bit positions
`define IOLCP_PB_LINE4      0
`define IOLCP_PB_LINE3      1
`define IOLCP_PB_SLEEP      6
`define IOLCP_PB_DIN        7

// timing
`define IOLCP_CLK_NS          20
`define IOLCP_PWM_PERIOD_US   64
`define IOLCP_PWM_STEPS       10'h3FF
`define IOLCP_PERIOD_CYCLES   ((`IOLCP_PWM_PERIOD_US * 1000) / `IOLCP_CLK_NS)
`define IOLCP_TICK_MS         100
`define IOLCP_TICK_CYCLES     ((`IOLCP_TICK_MS * 1000000) / `IOLCP_CLK_NS)

`endif

// ==== pkg/iolcp_pkg.sv ====
// types of the i/o line configuration and pwm block
`default_nettype none
`include "iolcp_regs.svh"
package iolcp_pkg;

  typedef logic [2:0]  iolcp_sel_t;
  typedef logic [9:0]  iolcp_duty_t;
  typedef logic [4:0]  iolcp_id_t;

  typedef struct packed {
    iolcp_sel_t  line3;
    iolcp_sel_t  line4;
    iolcp_sel_t  line5;
    iolcp_sel_t  sleep;
    iolcp_sel_t  second_pulse_output;
    iolcp_sel_t  pwm2;
    iolcp_sel_t  th_miso;
    iolcp_sel_t  smt_miso;
    iolcp_sel_t  smt_mosi;
    iolcp_sel_t  smt_ssel;
    iolcp_sel_t  smt_sclk;
    iolcp_sel_t  smt_attn;
    iolcp_duty_t duty1;
    iolcp_duty_t duty2;
    logic [7:0]  pull_en;
    logic [7:0]  pull_dir;
    logic        fwd;
    logic [15:0] src_bind;
    logic [7:0]  tmo;
  } iolcp_cfg_s;

  localparam iolcp_cfg_s IOLCP_CFG_RST = '{
    line3: `IOLCP_RST_LINE3, line4: `IOLCP_RST_LINE4, line5: `IOLCP_RST_LINE5,
    sleep: `IOLCP_RST_SLEEP, second_pulse_output: `IOLCP_RST_SECOND_PULSE_OUTPUT, pwm2: `IOLCP_RST_PWM2,
    th_miso: `IOLCP_RST_TH_MISO, smt_miso: `IOLCP_RST_SMT, smt_mosi: `IOLCP_RST_SMT,
    smt_ssel: `IOLCP_RST_SMT, smt_sclk: `IOLCP_RST_SMT, smt_attn: `IOLCP_RST_SMT,
    duty1: `IOLCP_RST_DUTY, duty2: `IOLCP_RST_DUTY, pull_en: `IOLCP_RST_PULL_EN,
    pull_dir: `IOLCP_RST_PULL_DIR, fwd: `IOLCP_RST_FWD, src_bind: `IOLCP_RST_BIND,
    tmo: `IOLCP_RST_TIMEOUT};

endpackage : iolcp_pkg
`default_nettype wire

// ==== pkg/iolcp_pwm_if.sv ====
// link between the shared pwm timebase and one pwm channel
`timescale 1ns/100ps
`default_nettype none
interface iolcp_pwm_if;
  logic [9:0] step;
  logic [9:0] duty;
  logic       en;
  logic       pwm_out;
  modport timebase (output step, output duty, output en, input pwm_out);
  modport chan (input step, input duty, input en, output pwm_out);
endinterface : iolcp_pwm_if
`default_nettype wire

// ==== hw/iolcp_pwm_chan.sv ====
// one pwm channel compared against the shared step counter
`timescale 1ns/100ps
`default_nettype none
`include "iolcp_regs.svh"
module iolcp_pwm_chan (
  input  wire logic     i_sys_clk,
  input  wire logic     i_srst,
  iolcp_pwm_if.chan     io_pwm
);
  import iolcp_pkg::*;

  typedef struct packed {
    logic out;
  } iolcp_chan_s;

  iolcp_chan_s s_ff;
  iolcp_chan_s nxt_s;

  // step never reaches full scale, so full-scale duty stays high all period
  always_comb begin
    nxt_s     = s_ff;
    nxt_s.out = io_pwm.en && (io_pwm.step < io_pwm.duty); // see RULE9
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign io_pwm.pwm_out = s_ff.out;

  chk_pwm_full_on: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see RULE9
    (io_pwm.en && io_pwm.duty == `IOLCP_PWM_STEPS) |=> io_pwm.pwm_out)
    else $error("full-scale duty did not drive the pwm high");
  chk_pwm_zero_off: assert property (@(posedge i_sys_clk) disable iff (i_srst) // see RULE9
    (io_pwm.duty == 10'h000) |=> !io_pwm.pwm_out)
    else $error("zero duty drove the pwm high");

endmodule : iolcp_pwm_chan
`default_nettype wire

// ==== hw/iolcp_top.sv ====
// i/o line function selectors, pull masks, pwm outputs and line passing
`timescale 1ns/100ps
`default_nettype none
`include "iolcp_regs.svh"
// Operation
// RULE1 - line three selector: disabled, slave select, analog, input, low, high; resets 0
// RULE2 - line four selector takes 0,1,3,4,5; value 2 refused; resets 0
// RULE3 - line five resets to association indicator; 3,4,5 give input, low, high
// RULE4 - sleep selector takes 0 or 3; the line always drives pin sleep
// RULE5 - no pull resistor on the sleep line while pin sleep is used
// RULE6 - first pwm selector: disabled, signal strength pwm, plain pwm; resets 1
// RULE7 - bound analog samples overwrite first pwm duty when plain pwm chosen
// RULE8 - second pwm selector takes 0 or 2, resets 0, follows bound samples
// RULE9 - pwm period 64 us in 0x3FF steps; duty gives proportional high time
// RULE10 - duties hold 0 to 0x3FF, reset 0; host applies settings to take effect
// RULE11 - through-hole miso selector takes 0 or 1, resets 0
// RULE12 - surface-mount spi selectors take 0 or 1, each resets 1
// RULE13 - pull enable mask is 8 bits, resets 0xFF, 1 connects resistor
// RULE14 - pull masks act only on lines that are inputs or disabled
// RULE15 - pull mask bits map line four, three, two, one, zero, six, sleep, data-in
// RULE16 - pull direction mask shares mapping, 1 is pull-up, resets 0xFF
// RULE17 - forwarding enable sends received samples out as frames; resets 1
// RULE18 - bound samples set output and pwm lines; 0xFFFF accepts every sender
// RULE19 - sample-set pwm reverts after timeout in 100 ms units; 0 never; reset 0xFF
// RULE20 - out-of-range selector writes are refused and leave the selector unchanged
module iolcp_top #(
  parameter int unsigned P_TICK_CYCLES = `IOLCP_TICK_CYCLES
) (
  input  wire logic              i_sys_clk,
  input  wire logic              i_srst,
  input  wire logic              i_wr_valid,
  input  wire iolcp_pkg::iolcp_id_t   i_wr_id,
  input  wire logic [15:0]       i_wr_data,
  input  wire logic              i_apply,
  input  wire logic              i_sample_valid,
  input  wire logic [15:0]       i_sample_src,
  input  wire logic [7:0]        i_sample_dio,
  input  wire iolcp_pkg::iolcp_duty_t i_sample_ad0,
  input  wire iolcp_pkg::iolcp_duty_t i_rssi_duty,
  input  wire logic              i_assoc_blink,
  input  wire logic              i_pin_sleep_en,
  input  wire logic              i_sleep_request_line,
  input  wire logic [3:0]        i_ext_line_idle,
  output logic                   o_reject,
  output logic                   o_io_forward,
  output iolcp_pkg::iolcp_sel_t  o_line_three_select,
  output iolcp_pkg::iolcp_sel_t  o_line_four_select,
  output iolcp_pkg::iolcp_sel_t  o_line_five_select,
  output iolcp_pkg::iolcp_sel_t  o_sleep_line_select,
  output iolcp_pkg::iolcp_sel_t  o_first_pwm_line_select,
  output iolcp_pkg::iolcp_sel_t  o_second_pwm_line_select,
  output iolcp_pkg::iolcp_sel_t  o_th_miso_select,
  output iolcp_pkg::iolcp_sel_t  o_smt_miso_select,
  output iolcp_pkg::iolcp_sel_t  o_smt_mosi_select,
  output iolcp_pkg::iolcp_sel_t  o_smt_slave_select_select,
  output iolcp_pkg::iolcp_sel_t  o_smt_sclk_select,
  output iolcp_pkg::iolcp_sel_t  o_smt_attention_select,
  output logic [2:0]             o_line_oe,
  output logic [2:0]             o_line_level,
  output logic [7:0]             o_pull_enable,
  output logic [7:0]             o_pull_up,
  output logic                   o_sleep_request,
  output logic                   o_first_pulse_output,
  output logic                   o_second_pulse_output
);
  import iolcp_pkg::*;

  typedef struct packed {
    iolcp_cfg_s  pend;
    iolcp_cfg_s  act;
    logic        reject;
    logic        fwd_pulse;
    logic        slp_meta;
    logic        slp_sync;
    logic        slp_out;
    logic        remote_act;
    iolcp_duty_t remote_duty;
    logic [2:0]  rdo;
    logic [2:0]  rdo_vld;
    logic [22:0] tick_cnt;
    logic [7:0]  tmo_cnt;
    logic [12:0] phase;
    logic [9:0]  step;
    iolcp_duty_t duty1;
    iolcp_duty_t duty2;
    logic        en1;
    logic        en2;
    logic [2:0]  line_oe;
    logic [2:0]  line_lvl;
    logic [7:0]  pull_en;
    logic [7:0]  pull_up;
  } iolcp_top_s;

  iolcp_top_s s_ff;
  iolcp_top_s nxt_s;
  logic       bound_hit;
  logic       tick;

  // 0xFFFF binding takes samples from any sender, broadcasts included
  assign bound_hit = i_sample_valid && ((s_ff.act.src_bind == `IOLCP_BIND_ANY) // see RULE18
                     || (i_sample_src == s_ff.act.src_bind));
  assign tick = (s_ff.tick_cnt == 23'(P_TICK_CYCLES - 1));

  always_comb begin
    logic       ok;
    logic       hi3;
    iolcp_sel_t d3;
    iolcp_sel_t lsel [3];
    logic [7:0] idle;
    nxt_s = s_ff;
    ok    = 1'b1;
    hi3   = |i_wr_data[15:3];
    d3    = i_wr_data[2:0];
    lsel  = '{default: 3'h0};
    idle  = 8'h00;
    nxt_s.reject    = 1'b0;
    nxt_s.fwd_pulse = i_sample_valid && s_ff.act.fwd; // see RULE17
    // settings land in the pending copy; refused values leave it untouched
    if (i_wr_valid) begin
      case (i_wr_id)
        `IOLCP_ID_LINE3: ok = !hi3 && d3 <= `IOLCP_SEL_OUT_HIGH; // see RULE1
        `IOLCP_ID_LINE4, `IOLCP_ID_LINE5: ok = !hi3 && d3 <= `IOLCP_SEL_OUT_HIGH
                                              && d3 != `IOLCP_SEL_ANALOG; // see RULE2
        `IOLCP_ID_SLEEP: ok = !hi3 && (d3 == `IOLCP_SEL_DISABLED || d3 == `IOLCP_SEL_DIN); // see RULE4
        `IOLCP_ID_SECOND_PULSE_OUTPUT_SEL: ok = !hi3 && d3 <= `IOLCP_PWM_PLAIN; // see RULE6
        `IOLCP_ID_PWM2_SEL: ok = !hi3 && (d3 == `IOLCP_SEL_DISABLED
                                          || d3 == `IOLCP_PWM_PLAIN); // see RULE8
        `IOLCP_ID_TH_MISO, `IOLCP_ID_SMT_MISO, `IOLCP_ID_SMT_MOSI, `IOLCP_ID_SMT_SSEL,
        `IOLCP_ID_SMT_SCLK, `IOLCP_ID_SMT_ATTN: ok = !hi3 && d3 <= `IOLCP_SEL_SPI; // see RULE11
        `IOLCP_ID_DUTY1, `IOLCP_ID_DUTY2: ok = ~|i_wr_data[15:10]; // see RULE10
        `IOLCP_ID_PULL_EN, `IOLCP_ID_PULL_DIR, `IOLCP_ID_TIMEOUT: ok = ~|i_wr_data[15:8];
        `IOLCP_ID_FWD_EN: ok = ~|i_wr_data[15:1];
        `IOLCP_ID_BIND: ok = 1'b1;
        default: ok = 1'b0;
      endcase
      if (!ok) begin
        nxt_s.reject = 1'b1; // see RULE20
      end else begin
        case (i_wr_id)
          `IOLCP_ID_LINE3:    nxt_s.pend.line3    = d3;
          `IOLCP_ID_LINE4:    nxt_s.pend.line4    = d3;
          `IOLCP_ID_LINE5:    nxt_s.pend.line5    = d3; // see RULE3
          `IOLCP_ID_SLEEP:    nxt_s.pend.sleep    = d3;
          `IOLCP_ID_SECOND_PULSE_OUTPUT_SEL: nxt_s.pend.second_pulse_output     = d3;
          `IOLCP_ID_PWM2_SEL: nxt_s.pend.pwm2     = d3;
          `IOLCP_ID_TH_MISO:  nxt_s.pend.th_miso  = d3;
          `IOLCP_ID_SMT_MISO: nxt_s.pend.smt_miso = d3; // see RULE12
          `IOLCP_ID_SMT_MOSI: nxt_s.pend.smt_mosi = d3;
          `IOLCP_ID_SMT_SSEL: nxt_s.pend.smt_ssel = d3;
          `IOLCP_ID_SMT_SCLK: nxt_s.pend.smt_sclk = d3;
          `IOLCP_ID_SMT_ATTN: nxt_s.pend.smt_attn = d3;
          `IOLCP_ID_DUTY1:    nxt_s.pend.duty1    = i_wr_data[9:0];
          `IOLCP_ID_DUTY2:    nxt_s.pend.duty2    = i_wr_data[9:0];
          `IOLCP_ID_PULL_EN:  nxt_s.pend.pull_en  = i_wr_data[7:0]; // see RULE13
          `IOLCP_ID_PULL_DIR: nxt_s.pend.pull_dir = i_wr_data[7:0]; // see RULE16
          `IOLCP_ID_FWD_EN:   nxt_s.pend.fwd      = i_wr_data[0];
          `IOLCP_ID_BIND:     nxt_s.pend.src_bind = i_wr_data;
          `IOLCP_ID_TIMEOUT:  nxt_s.pend.tmo      = i_wr_data[7:0];
          default:            nxt_s.reject        = 1'b1;
        endcase
      end
    end

    // apply drops sample-set values; a sample in the same cycle still wins
    if (i_apply) begin
      nxt_s.act        = s_ff.pend; // see RULE10
      nxt_s.remote_act = 1'b0;
      nxt_s.rdo_vld    = 3'h0;
    end

    // 100 ms base for the revert timeout
    nxt_s.tick_cnt = tick ? 23'h000000 : s_ff.tick_cnt + 23'h000001;
    if (bound_hit) begin
      if (s_ff.act.second_pulse_output == `IOLCP_PWM_PLAIN || s_ff.act.pwm2 == `IOLCP_PWM_PLAIN) begin
        nxt_s.remote_duty = i_sample_ad0; // see RULE7
        nxt_s.remote_act  = 1'b1; // see RULE8
        nxt_s.tmo_cnt     = s_ff.act.tmo;
      end
      lsel = '{s_ff.act.line3, s_ff.act.line4, s_ff.act.line5};
      for (int i = 0; i < 3; i++) begin
        if (lsel[i] == `IOLCP_SEL_OUT_LOW || lsel[i] == `IOLCP_SEL_OUT_HIGH) begin
          nxt_s.rdo_vld[i] = 1'b1; // see RULE18
          nxt_s.rdo[i]     = i_sample_dio[3 + i];
        end
      end
    end else if (s_ff.remote_act && s_ff.act.tmo != 8'h00 && tick) begin
      // zero timeout keeps the sample value for good
      if (s_ff.tmo_cnt <= 8'h01) begin
        nxt_s.remote_act = 1'b0; // see RULE19
      end else begin
        nxt_s.tmo_cnt = s_ff.tmo_cnt - 8'h01;
      end
    end

    // fractional timebase: 1023 steps spread evenly over 3200 cycles
    if (s_ff.phase + 13'(`IOLCP_PWM_STEPS) >= 13'(`IOLCP_PERIOD_CYCLES)) begin
      nxt_s.phase = s_ff.phase + 13'(`IOLCP_PWM_STEPS) - 13'(`IOLCP_PERIOD_CYCLES); // see RULE9
      nxt_s.step  = (s_ff.step == `IOLCP_PWM_STEPS - 10'h001) ? 10'h000
                    : s_ff.step + 10'h001;
    end else begin
      nxt_s.phase = s_ff.phase + 13'(`IOLCP_PWM_STEPS);
    end

    nxt_s.en1   = nxt_s.act.second_pulse_output != `IOLCP_SEL_DISABLED; // see RULE6
    nxt_s.duty1 = 10'h000;
    case (nxt_s.act.second_pulse_output)
      `IOLCP_PWM_RSSI:  nxt_s.duty1 = i_rssi_duty;
      `IOLCP_PWM_PLAIN: nxt_s.duty1 = nxt_s.remote_act ? nxt_s.remote_duty : nxt_s.act.duty1;
      default:          nxt_s.duty1 = 10'h000;
    endcase
    nxt_s.en2   = nxt_s.act.pwm2 == `IOLCP_PWM_PLAIN; // see RULE8
    nxt_s.duty2 = !nxt_s.en2 ? 10'h000
                  : nxt_s.remote_act ? nxt_s.remote_duty : nxt_s.act.duty2;

    lsel = '{nxt_s.act.line3, nxt_s.act.line4, nxt_s.act.line5};
    for (int i = 0; i < 3; i++) begin
      nxt_s.line_oe[i]  = lsel[i] == `IOLCP_SEL_OUT_LOW || lsel[i] == `IOLCP_SEL_OUT_HIGH;
      nxt_s.line_lvl[i] = nxt_s.rdo_vld[i] ? nxt_s.rdo[i] : lsel[i] == `IOLCP_SEL_OUT_HIGH;
    end
    if (nxt_s.act.line5 == `IOLCP_SEL_SPI) begin
      nxt_s.line_oe[2]  = 1'b1; // see RULE3
      nxt_s.line_lvl[2] = i_assoc_blink;
    end

    // pulls only reach lines that are inputs or disabled
    idle[`IOLCP_PB_LINE4] = lsel[1] == `IOLCP_SEL_DISABLED || lsel[1] == `IOLCP_SEL_DIN; // see RULE15
    idle[`IOLCP_PB_LINE3] = lsel[0] == `IOLCP_SEL_DISABLED || lsel[0] == `IOLCP_SEL_DIN;
    idle[5:2]             = i_ext_line_idle;
    idle[`IOLCP_PB_SLEEP] = !i_pin_sleep_en; // see RULE5
    idle[`IOLCP_PB_DIN]   = 1'b1;
    nxt_s.pull_en = nxt_s.act.pull_en & idle; // see RULE14
    nxt_s.pull_up = nxt_s.act.pull_dir & idle;

    // sleep request pin always steers pin sleep, whatever its selector holds
    nxt_s.slp_meta = i_sleep_request_line; // see RULE4
    nxt_s.slp_sync = s_ff.slp_meta;
    nxt_s.slp_out  = s_ff.slp_sync;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      s_ff      <= '0;
      s_ff.pend <= IOLCP_CFG_RST;
      s_ff.act  <= IOLCP_CFG_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  iolcp_pwm_if u_second_pulse_output_if ();
  iolcp_pwm_if u_pwm2_if ();
  assign u_second_pulse_output_if.step = s_ff.step;
  assign u_second_pulse_output_if.duty = s_ff.duty1;
  assign u_second_pulse_output_if.en   = s_ff.en1;
  assign u_pwm2_if.step = s_ff.step;
  assign u_pwm2_if.duty = s_ff.duty2;
  assign u_pwm2_if.en   = s_ff.en2;

  iolcp_pwm_chan u_second_pulse_output (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .io_pwm    (u_second_pulse_output_if.chan)
  );
  iolcp_pwm_chan u_pwm2 (
    .i_sys_clk (i_sys_clk),
    .i_srst    (i_srst),
    .io_pwm    (u_pwm2_if.chan)
  );

  assign o_reject                  = s_ff.reject;
  assign o_io_forward              = s_ff.fwd_pulse;
  assign o_line_three_select       = s_ff.act.line3;
  assign o_line_four_select        = s_ff.act.line4;
  assign o_line_five_select        = s_ff.act.line5;
  assign o_sleep_line_select       = s_ff.act.sleep;
  assign o_first_pwm_line_select   = s_ff.act.second_pulse_output;
  assign o_second_pwm_line_select  = s_ff.act.pwm2;
  assign o_th_miso_select          = s_ff.act.th_miso;
  assign o_smt_miso_select         = s_ff.act.smt_miso;
  assign o_smt_mosi_select         = s_ff.act.smt_mosi;
  assign o_smt_slave_select_select = s_ff.act.smt_ssel;
  assign o_smt_sclk_select         = s_ff.act.smt_sclk;
  assign o_smt_attention_select    = s_ff.act.smt_attn;
  assign o_line_oe                 = s_ff.line_oe;
  assign o_line_level              = s_ff.line_lvl;
  assign o_pull_enable             = s_ff.pull_en;
  assign o_pull_up                 = s_ff.pull_up;
  assign o_sleep_request           = s_ff.slp_out;
  assign o_first_pulse_output      = u_second_pulse_output_if.pwm_out;
  assign o_second_pulse_output     = u_pwm2_if.pwm_out;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_srst);

  sequence s_plain1_hit;
    bound_hit && s_ff.act.second_pulse_output == `IOLCP_PWM_PLAIN && !i_apply;
  endsequence
  sequence s_plain2_hit;
    bound_hit && s_ff.act.pwm2 == `IOLCP_PWM_PLAIN && !i_apply;
  endsequence

  chk_reset_values: assert property (disable iff (1'b0) i_srst |=> // see RULE1
    o_line_three_select == 3'h0 && o_line_five_select == 3'h1
    && o_first_pwm_line_select == 3'h1 && o_smt_attention_select == 3'h1)
    else $error("selector reset values wrong");
  chk_mask_reset: assert property (disable iff (1'b0) i_srst |=> // see RULE13
    s_ff.act.pull_en == 8'hFF && s_ff.act.pull_dir == 8'hFF && s_ff.act.tmo == 8'hFF)
    else $error("mask or timeout reset value wrong");
  chk_line4_refuse: assert property ((i_wr_valid && i_wr_id == `IOLCP_ID_LINE4 // see RULE2
    && i_wr_data == 16'h0002) |=> o_reject && $stable(s_ff.pend.line4))
    else $error("line four accepted value 2");
  chk_bad_select: assert property ((i_wr_valid && i_wr_id == `IOLCP_ID_SLEEP // see RULE20
    && i_wr_data == 16'h0001) |=> o_reject && $stable(s_ff.pend.sleep))
    else $error("sleep selector accepted a refused value");
  chk_sleep_follow: assert property (!$past(i_srst, 3) |-> // see RULE4
    o_sleep_request == $past(i_sleep_request_line, 3))
    else $error("sleep request not passed through three flops");
  chk_sleep_no_pull: assert property (i_pin_sleep_en |=> !o_pull_enable[6]) // see RULE5
    else $error("pull applied to sleep line during pin sleep");
  chk_pull_gated: assert property ((s_ff.act.line3 == `IOLCP_SEL_OUT_HIGH && !i_apply) // see RULE14
    |=> !o_pull_enable[1] && !o_pull_up[1])
    else $error("pull applied to an output line");
  chk_second_pulse_output_sample: assert property (s_plain1_hit |=> s_ff.duty1 == $past(i_sample_ad0)) // see RULE7
    else $error("first pwm duty did not follow the sample");
  chk_pwm2_sample: assert property (s_plain2_hit |=> s_ff.duty2 == $past(i_sample_ad0)) // see RULE8
    else $error("second pwm duty did not follow the sample");
  chk_forward: assert property ((i_sample_valid && s_ff.act.fwd) |=> o_io_forward // see RULE17
    ##1 !o_io_forward || $past(i_sample_valid))
    else $error("received sample not forwarded");
  chk_revert: assert property ((s_ff.remote_act && s_ff.tmo_cnt == 8'h01 && tick // see RULE19
    && s_ff.act.tmo != 8'h00 && !bound_hit) |=> !s_ff.remote_act)
    else $error("pwm did not revert at timeout");

endmodule : iolcp_top
`default_nettype wire

// ==== tb/iolcp_host_model.sv ====
// host model issuing setting writes and apply commands
`timescale 1ns/100ps
`default_nettype none
module iolcp_host_model (
  input  wire logic            i_sys_clk,
  input  wire logic            i_reject,
  output logic                 o_wr_valid,
  output iolcp_pkg::iolcp_id_t o_wr_id,
  output logic [15:0]          o_wr_data,
  output logic                 o_apply
);
  import iolcp_pkg::*;
  initial begin
    o_wr_valid = 1'b0;
    o_wr_id = 5'h00;
    o_wr_data = 16'h0000;
    o_apply = 1'b0;
  end
  // one idle cycle between writes keeps each strobe edge clean
  task automatic wr(input iolcp_id_t id, input logic [15:0] d, output logic rj);
    @(posedge i_sys_clk);
    o_wr_valid <= 1'b1;
    o_wr_id <= id;
    o_wr_data <= d;
    @(posedge i_sys_clk);
    o_wr_valid <= 1'b0;
    #1 rj = i_reject;
  endtask : wr
  // nothing written counts until applied
  task automatic apply();
    @(posedge i_sys_clk);
    o_apply <= 1'b1;
    @(posedge i_sys_clk);
    o_apply <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
  endtask : apply
endmodule : iolcp_host_model
`default_nettype wire

// ==== tb/iolcp_top_test.sv ====
// self-checking bench of the line configuration and pwm block
`timescale 1ns/100ps
`default_nettype none
`include "iolcp_regs.svh"
module iolcp_top_test;
  import iolcp_pkg::*;
  typedef struct {iolcp_id_t id; logic [15:0] d; logic rj;} iolcp_row_s;
  logic clk = 1'b0, srst = 1'b1, sv = 1'b0, blink = 1'b0, pse = 1'b0, slp = 1'b0;
  logic [15:0] src = 16'h0000;
  logic [7:0] dio = 8'h00;
  iolcp_duty_t ad0 = 10'h000, rssi = 10'h3FF;
  logic [3:0] idle = 4'hF;
  logic wv, ap, rej, fwd, slo, q1, q2, rj;
  iolcp_id_t wid;
  logic [15:0] wd;
  iolcp_sel_t s3, s4, s5, s8, p1, p2, th, sm0, sm1, sm2, sm3, sm4;
  logic [2:0] oe, lvl;
  logic [7:0] pen, pup;
  int fail_count = 0, n_tests = 0, cyc = 0;
  integer h1, h2;
  iolcp_row_s rows [16] = '{
    '{`IOLCP_ID_LINE4, 16'h2, 1'b1}, '{`IOLCP_ID_LINE3, 16'h5, 1'b0},
    '{`IOLCP_ID_SLEEP, 16'h1, 1'b1}, '{`IOLCP_ID_SLEEP, 16'h3, 1'b0},
    '{`IOLCP_ID_PWM2_SEL, 16'h1, 1'b1}, '{`IOLCP_ID_PWM2_SEL, 16'h2, 1'b0},
    '{`IOLCP_ID_SECOND_PULSE_OUTPUT_SEL, 16'h3, 1'b1}, '{`IOLCP_ID_SECOND_PULSE_OUTPUT_SEL, 16'h2, 1'b0},
    '{`IOLCP_ID_TH_MISO, 16'h2, 1'b1}, '{`IOLCP_ID_SMT_ATTN, 16'h0, 1'b0},
    '{`IOLCP_ID_SMT_MISO, 16'h2, 1'b1}, '{`IOLCP_ID_LINE5, 16'h2, 1'b1},
    '{`IOLCP_ID_LINE5, 16'h4, 1'b0}, '{`IOLCP_ID_DUTY1, 16'h400, 1'b1},
    '{`IOLCP_ID_DUTY1, 16'h1FF, 1'b0}, '{`IOLCP_ID_LINE4, 16'h4, 1'b0}};
  always #10 clk = ~clk;
  iolcp_host_model host (.i_sys_clk(clk), .i_reject(rej), .o_wr_valid(wv), .o_wr_id(wid),
    .o_wr_data(wd), .o_apply(ap));
  iolcp_top #(.P_TICK_CYCLES(20)) dut (.i_sys_clk(clk), .i_srst(srst), .i_wr_valid(wv),
    .i_wr_id(wid), .i_wr_data(wd), .i_apply(ap), .i_sample_valid(sv), .i_sample_src(src),
    .i_sample_dio(dio), .i_sample_ad0(ad0), .i_rssi_duty(rssi), .i_assoc_blink(blink),
    .i_pin_sleep_en(pse), .i_sleep_request_line(slp), .i_ext_line_idle(idle),
    .o_reject(rej), .o_io_forward(fwd), .o_line_three_select(s3), .o_line_four_select(s4),
    .o_line_five_select(s5), .o_sleep_line_select(s8), .o_first_pwm_line_select(p1),
    .o_second_pwm_line_select(p2), .o_th_miso_select(th), .o_smt_miso_select(sm0),
    .o_smt_mosi_select(sm1), .o_smt_slave_select_select(sm2), .o_smt_sclk_select(sm3),
    .o_smt_attention_select(sm4), .o_line_oe(oe), .o_line_level(lvl), .o_pull_enable(pen),
    .o_pull_up(pup), .o_sleep_request(slo), .o_first_pulse_output(q1),
    .o_second_pulse_output(q2));
  task automatic chk(input string n, input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // one full pwm period, any phase
  task automatic meas();
    h1 = 0;
    h2 = 0;
    repeat (3200) begin
      @(posedge clk);
      #1 h1 += q1;
      h2 += q2;
    end
  endtask : meas
  task automatic samp(input logic [15:0] s, input logic [7:0] d, output logic f);
    @(posedge clk);
    sv <= 1'b1;
    src <= s;
    dio <= d;
    ad0 <= 10'h3FF;
    @(posedge clk);
    sv <= 1'b0;
    #1 f = fwd;
  endtask : samp
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    blink <= 1'b1;
    step(3);
    chk("rst_sel_a", {s3, s4, s5, s8}, {3'h0, 3'h0, 3'h1, 3'h0});
    chk("rst_sel_b", {p1, p2, th}, {3'h1, 3'h0, 3'h0});
    chk("rst_smt", {sm0, sm1, sm2, sm3, sm4}, {5{3'h1}});
    chk("rst_pull", {pen, pup}, 16'hFFFF);
    chk("blink", lvl[2], 1'b1);
    meas();
    chk("rssi_pwm", h1, 16'd3200);
    foreach (rows[i]) begin
      host.wr(rows[i].id, rows[i].d, rj);
      chk("reject", rj, rows[i].rj);
    end
    host.apply();
    chk("sel_a", {s3, s4, s5, s8}, {3'h5, 3'h4, 3'h4, 3'h3});
    chk("sel_b", {p1, p2, th, sm0, sm4}, {3'h2, 3'h2, 3'h0, 3'h1, 3'h0});
    chk("lines", {oe, lvl}, {3'h7, 3'h1});
    chk("pull", {pen, pup}, 16'hFCFC);
    meas();
    chk("half", h1 > 1590 && h1 < 1607, 1'b1);
    chk("zero", h2, 16'd0);
    pse <= 1'b1;
    slp <= 1'b1;
    idle <= 4'hE;
    step(5);
    chk("pull_slp", {pen, pup}, 16'hB8B8);
    chk("slp_pin", slo, 1'b1);
    samp(16'h1234, 8'h00, rj);
    step(2);
    chk("fwd_any", {rj, lvl}, {1'b1, 3'h1});
    samp(16'h0000, 8'h28, rj);
    step(2);
    chk("bound", {rj, lvl}, {1'b1, 3'h5});
    meas();
    chk("follow_1", h1, 16'd3200);
    chk("follow_2", h2, 16'd3200);
    host.wr(`IOLCP_ID_TIMEOUT, 16'h1, rj);
    host.wr(`IOLCP_ID_FWD_EN, 16'h0, rj);
    host.apply();
    samp(16'h0000, 8'h28, rj);
    chk("fwd_off", rj, 1'b0);
    step(60);
    meas();
    chk("revert_1", h1 > 1590 && h1 < 1607, 1'b1);
    chk("revert_2", h2, 16'd0);
    host.wr(`IOLCP_ID_TIMEOUT, 16'h0, rj);
    host.wr(`IOLCP_ID_BIND, 16'hFFFF, rj);
    host.apply();
    samp(16'h1234, 8'h28, rj);
    step(60);
    chk("any_src", lvl, 3'h5);
    meas();
    chk("no_tmo", h2, 16'd3200);
    print_verdict();
  end
endmodule : iolcp_top_test
`default_nettype wire
